// ==== inc/caf_pkg.sv ====
// Constants and types shared by the acceptance filter and error counter block.
package caf_pkg;

  // Register word indices; the byte address on the bus is four times the index.
  localparam logic [4:0] IDX_CTRL     = 5'h00;
  localparam logic [4:0] IDX_STATUS   = 5'h01;
  localparam logic [4:0] IDX_FILT_CTL = 5'h0B;
  localparam logic [4:0] IDX_MISC     = 5'h0D;
  localparam logic [4:0] IDX_RECEIVE_ERROR_COUNT    = 5'h0E;
  localparam logic [4:0] IDX_TRANSMIT_ERROR_COUNT    = 5'h0F;
  localparam logic [4:0] IDX_CODE0    = 5'h10;
  localparam logic [4:0] IDX_MASK0    = 5'h14;
  localparam logic [4:0] IDX_CODE4    = 5'h18;
  localparam logic [4:0] IDX_MASK4    = 5'h1C;
  localparam int         ADR_LSB      = 2;
  localparam int         IDX_W        = 5;

  // Control word fields.
  localparam int CTRL_INIT_REQ_BIT  = 0;
  localparam int CTRL_SLEEP_REQ_BIT = 1;
  localparam int CTRL_RECOV_SEL_BIT = 7;

  // Status word fields.
  localparam int STAT_INIT_ACK_BIT  = 0;
  localparam int STAT_SLEEP_ACK_BIT = 1;
  localparam int STAT_BUSOFF_BIT    = 2;
  localparam int STAT_FG_FULL_BIT   = 3;

  // Filter control word fields.
  localparam int FILT_ORG_LSB = 4;
  localparam int FILT_ORG_MSB = 5;
  localparam int FILT_HIT_LSB = 0;
  localparam int FILT_HIT_MSB = 2;

  // Miscellaneous word fields.
  localparam int MISC_HOLD_BIT = 0;

  // Reset values.
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_ID   = 32'h0000_0000;

  // Filter geometry.
  localparam int NUM_FILT  = 8;
  localparam int ID_BYTES  = 4;

  // Filter organisation; the encoding order is the register encoding.
  typedef enum logic [1:0] {
    ORG_TWO32,
    ORG_FOUR16,
    ORG_EIGHT8,
    ORG_CLOSED
  } caf_org_t;

endpackage

// ==== hw/caf_accept_filter.sv ====
// Identifier acceptance filter, error counter views and bus-off hold flag.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps

module caf_accept_filter #(
  parameter int ADR_W = 7
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Protocol engine status
  input  wire logic [7:0]        rx_err_count_i,
  input  wire logic [7:0]        tx_err_count_i,
  input  wire logic              busoff_i,
  // Received frames
  input  wire logic              frame_valid_i,
  input  wire logic [31:0]       frame_id_i,
  input  wire logic              frame_ext_i,
  // Results
  output logic                   rx_accept_o,
  output logic      [2:0]        rx_hit_o,
  output logic      [31:0]       fg_id_o,
  output logic                   busoff_hold_o,
  output logic                   busoff_recover_o,
  output logic                   init_mode_ack_o,
  output logic                   sleep_ack_o
);

  if (ADR_W < caf_pkg::IDX_W + caf_pkg::ADR_LSB) begin : g_adr_check
    $error("ADR_W too small for the register map");
  end

  // Bus decode.
  logic [caf_pkg::IDX_W-1:0] idx;
  logic                      req;
  logic                      wr_take;
  logic                      init_mode;

  assign idx       = wb_adr_i[caf_pkg::ADR_LSB +: caf_pkg::IDX_W];
  assign req       = wb_cyc_i && wb_stb_i;
  // A write takes effect at the edge where the master samples ack high.
  assign wr_take   = req && wb_we_i && wb_ack_o && wb_sel_i[0];

  // Control state.
  logic                init_req;
  logic                sleep_req;
  logic                recov_sel;
  caf_pkg::caf_org_t   org;
  logic [7:0]          code_q [caf_pkg::NUM_FILT];
  logic [7:0]          mask_q [caf_pkg::NUM_FILT];
  logic [7:0]          rx_err;
  logic [7:0]          tx_err;
  logic                busoff_q;
  logic [31:0]         bg_id;
  logic                bg_ext;
  logic                bg_valid;
  logic                fg_full;
  logic [caf_pkg::NUM_FILT-1:0] filt_hit;
  logic                any_hit;
  logic [2:0]          hit_num;
  logic [31:0]         next_rdata;

  assign init_mode = init_req && init_mode_ack_o;

  function automatic logic [caf_pkg::IDX_W-1:0] code_idx(input int k);
    code_idx = (k < 4) ? caf_pkg::IDX_CODE0 + caf_pkg::IDX_W'(k)
                       : caf_pkg::IDX_CODE4 + caf_pkg::IDX_W'(k - 4);
  endfunction

  function automatic logic [caf_pkg::IDX_W-1:0] mask_idx(input int k);
    mask_idx = (k < 4) ? caf_pkg::IDX_MASK0 + caf_pkg::IDX_W'(k)
                       : caf_pkg::IDX_MASK4 + caf_pkg::IDX_W'(k - 4);
  endfunction

  // A byte matches when every bit whose mask is zero equals its code bit.
  function automatic logic byte_ok(input logic [7:0] code, input logic [7:0] mask,
                                   input logic [7:0] id);
    byte_ok = ~|((code ^ id) & ~mask);
  endfunction

  function automatic logic [7:0] id_byte(input logic [31:0] id, input int j);
    id_byte = id[31 - 8 * j -: 8];
  endfunction

  // Wishbone answer: one wait state, ack for one cycle, unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= caf_pkg::RST_WORD;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  always_comb begin
    next_rdata = caf_pkg::RST_WORD;
    unique case (idx)
      caf_pkg::IDX_CTRL: begin
        next_rdata[caf_pkg::CTRL_INIT_REQ_BIT]  = init_req;
        next_rdata[caf_pkg::CTRL_SLEEP_REQ_BIT] = sleep_req;
        next_rdata[caf_pkg::CTRL_RECOV_SEL_BIT] = recov_sel;
      end
      caf_pkg::IDX_STATUS: begin
        next_rdata[caf_pkg::STAT_INIT_ACK_BIT]  = init_mode_ack_o;
        next_rdata[caf_pkg::STAT_SLEEP_ACK_BIT] = sleep_ack_o;
        next_rdata[caf_pkg::STAT_BUSOFF_BIT]    = busoff_q;
        next_rdata[caf_pkg::STAT_FG_FULL_BIT]   = fg_full;
      end
      caf_pkg::IDX_FILT_CTL: begin
        next_rdata[caf_pkg::FILT_ORG_MSB:caf_pkg::FILT_ORG_LSB] = org;
        next_rdata[caf_pkg::FILT_HIT_MSB:caf_pkg::FILT_HIT_LSB] = rx_hit_o;
      end
      caf_pkg::IDX_MISC: next_rdata[caf_pkg::MISC_HOLD_BIT] = busoff_hold_o;
      // Counter views are served in any mode; in every mode they trail the engine counters by one cycle.
      caf_pkg::IDX_RECEIVE_ERROR_COUNT: next_rdata[7:0] = rx_err;
      caf_pkg::IDX_TRANSMIT_ERROR_COUNT: next_rdata[7:0] = tx_err;
      default: begin
        for (int k = 0; k < caf_pkg::NUM_FILT; k++) begin
          if (idx == code_idx(k)) begin
            next_rdata[7:0] = code_q[k];
          end
          if (idx == mask_idx(k)) begin
            next_rdata[7:0] = mask_q[k];
          end
        end
      end
    endcase
  end

  // Mode control; the acknowledges follow their requests one cycle later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_req  <= 1'b0;
      sleep_req <= 1'b0;
      recov_sel <= 1'b0;
    end else if (wr_take && idx == caf_pkg::IDX_CTRL) begin
      init_req  <= wb_dat_i[caf_pkg::CTRL_INIT_REQ_BIT];
      sleep_req <= wb_dat_i[caf_pkg::CTRL_SLEEP_REQ_BIT];
      recov_sel <= wb_dat_i[caf_pkg::CTRL_RECOV_SEL_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_mode_ack_o <= 1'b0;
      sleep_ack_o     <= 1'b0;
    end else begin
      init_mode_ack_o <= init_req;
      sleep_ack_o     <= sleep_req;
    end
  end

  // Filter organisation is locked outside init mode, like the codes and masks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      org <= caf_pkg::ORG_TWO32;
    end else if (wr_take && init_mode && idx == caf_pkg::IDX_FILT_CTL) begin
      org <= caf_pkg::caf_org_t'(wb_dat_i[caf_pkg::FILT_ORG_MSB:caf_pkg::FILT_ORG_LSB]);
    end
  end

  // Code and mask bytes, one pair per filter entry.
  for (genvar k = 0; k < caf_pkg::NUM_FILT; k++) begin : g_regs
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        code_q[k] <= caf_pkg::RST_BYTE;
        mask_q[k] <= caf_pkg::RST_BYTE;
      end else if (wr_take && init_mode) begin
        if (idx == code_idx(k)) begin
          code_q[k] <= wb_dat_i[7:0];
        end
        if (idx == mask_idx(k)) begin
          mask_q[k] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // Error counter views, sampled so the read path is registered.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_err <= caf_pkg::RST_BYTE;
      tx_err <= caf_pkg::RST_BYTE;
    end else begin
      rx_err <= rx_err_count_i;
      tx_err <= tx_err_count_i;
    end
  end

  // Bus-off hold. Entry sets the flag when recov_sel is set; a set in the same cycle as a clear wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busoff_q <= 1'b0;
    end else begin
      busoff_q <= busoff_i;
    end
  end

  logic hold_clr;
  logic hold_set;
  assign hold_clr = wr_take && idx == caf_pkg::IDX_MISC && wb_dat_i[caf_pkg::MISC_HOLD_BIT];
  assign hold_set = recov_sel && busoff_i && !busoff_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busoff_hold_o <= 1'b0;
    end else if (!busoff_i) begin
      busoff_hold_o <= 1'b0;
    end else if (hold_set) begin
      busoff_hold_o <= 1'b1;
    end else if (hold_clr) begin
      busoff_hold_o <= 1'b0;
    end
  end

  // The engine leaves bus-off only on this pulse, sent when software clears a set flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busoff_recover_o <= 1'b0;
    end else begin
      busoff_recover_o <= hold_clr && busoff_hold_o && !hold_set && busoff_i;
    end
  end

  // Every frame is captured first, accepted or not; a reject is simply overwritten.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bg_id    <= caf_pkg::RST_ID;
      bg_ext   <= 1'b0;
      bg_valid <= 1'b0;
    end else begin
      bg_valid <= frame_valid_i;
      if (frame_valid_i) begin
        bg_id  <= frame_id_i;
        bg_ext <= frame_ext_i;
      end
    end
  end

  // Per-filter comparison against the background identifier.
  for (genvar k = 0; k < caf_pkg::NUM_FILT; k++) begin : g_filt
    localparam int B32 = (k % 2) * caf_pkg::ID_BYTES;
    localparam int B16 = (k % 4) * 2;
    logic f32;
    logic f16;
    logic f8;
    // Standard frames stop after two bytes, extended ones use all four.
    assign f32 = byte_ok(code_q[B32], mask_q[B32], id_byte(bg_id, 0))
              && byte_ok(code_q[B32+1], mask_q[B32+1], id_byte(bg_id, 1))
              && (!bg_ext
                  || (byte_ok(code_q[B32+2], mask_q[B32+2], id_byte(bg_id, 2))
                      && byte_ok(code_q[B32+3], mask_q[B32+3], id_byte(bg_id, 3))));
    assign f16 = byte_ok(code_q[B16], mask_q[B16], id_byte(bg_id, 0))
              && byte_ok(code_q[B16+1], mask_q[B16+1], id_byte(bg_id, 1));
    assign f8  = byte_ok(code_q[k], mask_q[k], id_byte(bg_id, 0));
    always_comb begin
      unique case (org)
        caf_pkg::ORG_TWO32:  filt_hit[k] = (k < 2) && f32;
        caf_pkg::ORG_FOUR16: filt_hit[k] = (k < 4) && f16;
        caf_pkg::ORG_EIGHT8: filt_hit[k] = f8;
        caf_pkg::ORG_CLOSED: filt_hit[k] = 1'b0;
      endcase
    end
  end

  // The lowest numbered filter that matches reports the hit.
  always_comb begin
    hit_num = 3'h0;
    for (int k = caf_pkg::NUM_FILT - 1; k >= 0; k--) begin
      if (filt_hit[k]) begin
        hit_num = 3'(k);
      end
    end
  end

  assign any_hit = |filt_hit;

  // Foreground load and CPU notification happen only for accepted frames.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_accept_o <= 1'b0;
    end else begin
      rx_accept_o <= bg_valid && any_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fg_id_o  <= caf_pkg::RST_ID;
      rx_hit_o <= 3'h0;
      fg_full  <= 1'b0;
    end else if (bg_valid && any_hit) begin
      fg_id_o  <= bg_id;
      rx_hit_o <= hit_num;
      fg_full  <= 1'b1;
    end
  end

  // Checks.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_frame_in;
    frame_valid_i ##1 bg_valid;
  endsequence

  sequence s_misc_write(logic bit_val);
    req && wb_we_i && wb_ack_o && wb_sel_i[0] && idx == caf_pkg::IDX_MISC
      && wb_dat_i[caf_pkg::MISC_HOLD_BIT] == bit_val;
  endsequence

  a_hold_w1c_clear: assert property (
    s_misc_write(1'b1) and !hold_set |=> !busoff_hold_o)
    else $error("hold flag not cleared by write of one");

  a_hold_w0_keep: assert property (
    s_misc_write(1'b0) and busoff_i && !hold_set |=> $stable(busoff_hold_o))
    else $error("hold flag changed by write of zero");

  a_hold_entry_set: assert property (
    recov_sel && busoff_i && !busoff_q |=> busoff_hold_o)
    else $error("hold flag not set on bus-off entry");

  a_hold_idle_zero: assert property (
    !busoff_i |=> !busoff_hold_o)
    else $error("hold flag set while not bus-off");

  a_receive_error_count_read: assert property (
    req && !wb_we_i && !wb_ack_o && idx == caf_pkg::IDX_RECEIVE_ERROR_COUNT
      |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(rx_err)})
    else $error("receive error count read wrong");

  a_transmit_error_count_read: assert property (
    req && !wb_we_i && !wb_ack_o && idx == caf_pkg::IDX_TRANSMIT_ERROR_COUNT
      |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(tx_err)})
    else $error("transmit error count read wrong");

  a_bg_capture: assert property (
    frame_valid_i |=> bg_id == $past(frame_id_i))
    else $error("frame not captured in background buffer");

  a_reject_silent: assert property (
    s_frame_in ##0 !any_hit |=> !rx_accept_o && $stable(fg_id_o))
    else $error("rejected frame signalled or loaded");

  a_accept_hit: assert property (
    s_frame_in ##0 any_hit |=> rx_accept_o && rx_hit_o == $past(hit_num)
      && fg_id_o == $past(bg_id))
    else $error("accepted frame not loaded with hit number");

  a_closed_none: assert property (
    org == caf_pkg::ORG_CLOSED |-> !any_hit)
    else $error("closed filter accepted a frame");

  a_locked_code: assert property (
    !init_mode |=> $stable(code_q[0]) && $stable(mask_q[7]))
    else $error("filter byte changed outside init mode");

endmodule

// ==== dv/caf_can_bus_model.sv ====
// Behavioural source of received frames standing for the other nodes on the bus.
`timescale 1ns/100ps

module caf_can_bus_model (
  // Clock
  input  wire logic        clk_i,
  // Frame delivery
  output logic             frame_valid_o,
  output logic      [31:0] frame_id_o,
  output logic             frame_ext_o
);
  initial begin
    frame_valid_o = 1'b0;
    frame_id_o    = 32'h0000_0000;
    frame_ext_o   = 1'b0;
  end

  // After each frame the lines show the inverse of its values (zero before the first), so stale data never matches.
  task automatic send(input logic [31:0] id, input logic ext);
    @(posedge clk_i);
    frame_valid_o <= 1'b1;
    frame_id_o    <= id;
    frame_ext_o   <= ext;
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
    frame_id_o    <= ~id;
    frame_ext_o   <= ~ext;
  endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the acceptance filter, counter views and bus-off hold flag.
`timescale 1ns/100ps

module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [6:0]  wb_adr_i = 7'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  rx_err_count_i = 8'h5A;
  logic [7:0]  tx_err_count_i = 8'hA5;
  logic        busoff_i = 1'b0;
  logic        frame_valid_i;
  logic [31:0] frame_id_i;
  logic        frame_ext_i;
  logic        rx_accept_o;
  logic [2:0]  rx_hit_o;
  logic [31:0] fg_id_o;
  logic        busoff_hold_o;
  logic        busoff_recover_o;
  logic        init_mode_ack_o;
  logic        sleep_ack_o;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #2 clk_i = ~clk_i;

  caf_can_bus_model u_can_bus (.clk_i(clk_i), .frame_valid_o(frame_valid_i),
    .frame_id_o(frame_id_i), .frame_ext_o(frame_ext_i));

  caf_accept_filter u_caf_accept_filter (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_err_count_i(rx_err_count_i), .tx_err_count_i(tx_err_count_i), .busoff_i(busoff_i),
    .frame_valid_i(frame_valid_i), .frame_id_i(frame_id_i), .frame_ext_i(frame_ext_i),
    .rx_accept_o(rx_accept_o), .rx_hit_o(rx_hit_o), .fg_id_o(fg_id_o),
    .busoff_hold_o(busoff_hold_o), .busoff_recover_o(busoff_recover_o),
    .init_mode_ack_o(init_mode_ack_o), .sleep_ack_o(sleep_ack_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Classic single cycle; the request holds until ack is sampled high.
  task automatic wb(input logic we, input logic [4:0] idx, input logic [7:0] wd,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h00_0000, wd};
    // Only the watchdog ends a wait for the acknowledge.
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk(r, {24'h00_0000, exp});
  endtask

  task automatic set_init(input logic on);
    logic [31:0] r;
    int          n;
    wr(caf_pkg::IDX_CTRL, {7'h00, on});
    n = 0;
    do begin
      wb(1'b0, caf_pkg::IDX_STATUS, 8'h00, r);
      n++;
    end while (r[caf_pkg::STAT_INIT_ACK_BIT] !== on && n < 20);
    chk({31'h0, r[caf_pkg::STAT_INIT_ACK_BIT]}, {31'h0, on});
    chk({31'h0, init_mode_ack_o}, {31'h0, on});
  endtask

  task automatic frame(input logic [31:0] id, input logic ext, input logic acc,
                       input logic [2:0] hit, input logic [31:0] fg);
    int seen;
    seen = 0;
    u_can_bus.send(id, ext);
    repeat (4) begin
      @(posedge clk_i);
      #1;
      if (rx_accept_o === 1'b1) seen++;
    end
    chk(seen, {31'h0, acc});
    chk({29'h0, rx_hit_o}, {29'h0, hit});
    chk(fg_id_o, fg);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 4; i++) rd_chk(5'(caf_pkg::IDX_MASK4 + i), 8'h00);
    wr(caf_pkg::IDX_CODE0, 8'hFF);
    rd_chk(caf_pkg::IDX_CODE0, 8'h00);
    rd_chk(5'h02, 8'h00);
    wr(caf_pkg::IDX_CTRL, 8'h02);
    rd_chk(caf_pkg::IDX_STATUS, 8'h02);
    chk({31'h0, sleep_ack_o}, 32'h1);
    rd_chk(caf_pkg::IDX_RECEIVE_ERROR_COUNT, 8'h5A);
    set_init(1'b1);
    rd_chk(caf_pkg::IDX_RECEIVE_ERROR_COUNT, 8'h5A);
    rd_chk(caf_pkg::IDX_TRANSMIT_ERROR_COUNT, 8'hA5);
    wr(caf_pkg::IDX_RECEIVE_ERROR_COUNT, 8'h11);
    wr(caf_pkg::IDX_TRANSMIT_ERROR_COUNT, 8'h22);
    rd_chk(caf_pkg::IDX_RECEIVE_ERROR_COUNT, 8'h5A);
    rd_chk(caf_pkg::IDX_TRANSMIT_ERROR_COUNT, 8'hA5);
    $display("Test registers done");
  endtask

  task automatic t_filters();
    logic [7:0] code [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE, 8'hF0};
    logic [7:0] mask [8] = '{8'h00, 8'h07, 8'h00, 8'h07, 8'h00, 8'h07, 8'h00, 8'h0F};
    for (int i = 0; i < 4; i++) begin
      wr(5'(caf_pkg::IDX_CODE0 + i), code[i]);
      wr(5'(caf_pkg::IDX_MASK0 + i), mask[i]);
      wr(5'(caf_pkg::IDX_CODE4 + i), code[i + 4]);
      wr(5'(caf_pkg::IDX_MASK4 + i), mask[i + 4]);
    end
    rd_chk(5'(caf_pkg::IDX_MASK4 + 3), 8'h0F);
    set_init(1'b0);
    frame(32'h1234_5678, 1'b1, 1'b1, 3'd0, 32'h1234_5678);
    frame(32'h1234_5778, 1'b1, 1'b0, 3'd0, 32'h1234_5678);
    frame(32'h9ABC_DEF5, 1'b1, 1'b1, 3'd1, 32'h9ABC_DEF5);
    frame(32'h9ABC_DE05, 1'b1, 1'b0, 3'd1, 32'h9ABC_DEF5);
    frame(32'h1233_AAAA, 1'b0, 1'b1, 3'd0, 32'h1233_AAAA);
    set_init(1'b1);
    wr(caf_pkg::IDX_FILT_CTL, {2'b00, caf_pkg::ORG_FOUR16, 4'h0});
    set_init(1'b0);
    frame(32'h5678_0000, 1'b1, 1'b1, 3'd1, 32'h5678_0000);
    frame(32'hDEF3_0000, 1'b1, 1'b1, 3'd3, 32'hDEF3_0000);
    frame(32'h1244_0000, 1'b1, 1'b0, 3'd3, 32'hDEF3_0000);
    set_init(1'b1);
    wr(caf_pkg::IDX_FILT_CTL, {2'b00, caf_pkg::ORG_EIGHT8, 4'h0});
    set_init(1'b0);
    frame(32'hBC00_0000, 1'b1, 1'b1, 3'd5, 32'hBC00_0000);
    frame(32'h1100_0000, 1'b1, 1'b0, 3'd5, 32'hBC00_0000);
    set_init(1'b1);
    wr(caf_pkg::IDX_FILT_CTL, {2'b00, caf_pkg::ORG_CLOSED, 4'h0});
    rd_chk(caf_pkg::IDX_FILT_CTL, 8'h35);
    set_init(1'b0);
    frame(32'h1234_5678, 1'b1, 1'b0, 3'd5, 32'hBC00_0000);
    $display("Test filters done");
  endtask

  task automatic t_busoff();
    wr(caf_pkg::IDX_CTRL, 8'h80);
    @(posedge clk_i);
    busoff_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, busoff_hold_o}, 32'h1);
    wr(caf_pkg::IDX_MISC, 8'h00);
    rd_chk(caf_pkg::IDX_MISC, 8'h01);
    wr(caf_pkg::IDX_MISC, 8'h01);
    #1;
    chk({30'h0, busoff_hold_o, busoff_recover_o}, 32'h1);
    rd_chk(caf_pkg::IDX_MISC, 8'h00);
    busoff_i <= 1'b0;
    @(posedge clk_i);
    busoff_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    busoff_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({31'h0, busoff_hold_o}, 32'h0);
    $display("Test bus-off done");
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_filters();
    t_busoff();
    close_out();
  end
endmodule
